// file: verilog/lme_pkg.sv
// package: shared constants and types of the literal/move/indirect unit
// assumes one 250 MHz core clock and the plain register port of lme_core
package lme_pkg;

  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int PCL_W = 7;
  localparam int FILE_W = 7;
  localparam int OFS_W = 6;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int FLAG_W = 3;

  // instruction codes as handed over by the fetch/decode stage
  typedef enum logic [2:0] {
    LME_OP_NOP = 3'h0,
    LME_OP_BANK = 3'h1,
    LME_OP_PAGE = 3'h2,
    LME_OP_ACCUM = 3'h3,
    LME_OP_STORE_FILE = 3'h4,
    LME_OP_STORE_IND = 3'h5,
    LME_OP_SW_RESET = 3'h6,
    LME_OP_OTHER = 3'h7
  } lme_op_e;

  typedef enum logic [1:0] {
    LME_MODE_PRE_INC = 2'h0,
    LME_MODE_PRE_DEC = 2'h1,
    LME_MODE_POST_INC = 2'h2,
    LME_MODE_POST_DEC = 2'h3
  } lme_mode_e;

  // file addresses that alias the indirect access ports
  localparam logic [FILE_W-1:0] IND0_ADDR = 7'h00;
  localparam logic [FILE_W-1:0] IND1_ADDR = 7'h01;

  // register port byte offsets
  localparam logic [BUS_AW-1:0] OFS_BANK = 8'h00;
  localparam logic [BUS_AW-1:0] OFS_PAGE = 8'h04;
  localparam logic [BUS_AW-1:0] OFS_ACCUM = 8'h08;
  localparam logic [BUS_AW-1:0] OFS_PTR0 = 8'h0C;
  localparam logic [BUS_AW-1:0] OFS_PTR1 = 8'h10;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 8'h14;
  localparam logic [BUS_AW-1:0] OFS_PWR = 8'h18;

  localparam int RI_BIT = 0;
  localparam logic RI_RESET = 1'b1;
  localparam logic [BANK_W-1:0] BANK_RESET = 5'h00;
  localparam logic [PCL_W-1:0] PAGE_RESET = 7'h00;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_PULSE_NS = 16;
  // least time: round up, at least one cycle
  localparam int RST_PULSE_RAW =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_PULSE_CYC = (RST_PULSE_RAW < 1) ? 1 : RST_PULSE_RAW;

endpackage

// file: verilog/lme_ptr_unit.sv
// pointer arithmetic for the indirect store: effective address and update
// assumes purely combinational use by lme_core
`timescale 1ns/1ps
module lme_ptr_unit #(
  parameter int PTR_W = lme_pkg::PTR_W
) (
  input wire logic [PTR_W-1:0] ptr,      // current pointer value
  input wire logic [1:0] mode,           // update mode field
  input wire logic rel,                  // relative offset form
  input wire logic [PTR_W-1:0] ofs_ext,  // sign-extended offset
  output logic [PTR_W-1:0] eff_addr,     // address written
  output logic [PTR_W-1:0] next_ptr      // pointer after the store
);

  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;

  // width-limited sums wrap across the whole 16-bit range
  assign ptr_inc = PTR_W'(ptr + 1'b1);
  assign ptr_dec = PTR_W'(ptr - 1'b1);

  always_comb begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (rel) begin
      eff_addr = PTR_W'(ptr + ofs_ext);
      next_ptr = ptr;
    end else begin
      unique case (lme_pkg::lme_mode_e'(mode))
        lme_pkg::LME_MODE_PRE_INC: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        lme_pkg::LME_MODE_PRE_DEC: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        lme_pkg::LME_MODE_POST_INC: begin
          eff_addr = ptr;
          next_ptr = ptr_inc;
        end
        lme_pkg::LME_MODE_POST_DEC: begin
          eff_addr = ptr;
          next_ptr = ptr_dec;
        end
      endcase
    end
  end

endmodule // lme_ptr_unit

// file: verilog/lme_rst_pulse.sv
// stretches the software reset trigger into a reset request pulse
// assumes the reset controller samples the request on sys_clk
`timescale 1ns/1ps
module lme_rst_pulse #(
  parameter int PULSE_CYC = lme_pkg::RST_PULSE_CYC
) (
  input wire logic sys_clk,  // core clock
  input wire logic rst_n,    // synchronous reset, active low
  input wire logic ce,       // clock enable
  input wire logic trigger,  // one-cycle start
  output logic req           // request to the reset controller
);

  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(PULSE_CYC);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (trigger) begin
      next_cnt = LOAD;
    end else if (cnt != '0) begin
      next_cnt = CW'(cnt - 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

  assign req = (cnt != '0);

  property p_rst_req_len;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && trigger) |=> req [*4];
  endproperty
  a_rst_req_len: assert property (p_rst_req_len)
    else $error("reset request shorter than its pulse length");

endmodule // lme_rst_pulse

// file: verilog/lme_core.sv
// execution of literal loads, accumulator stores, indirect stores, no-op
// and software reset; registers reachable over a plain read/write port
// assumes a decoder on sys_clk presents one instruction per valid cycle
//
// Behaviour
// - bank load copies 5-bit literal, flags kept
// - page load copies 7-bit literal, flags kept
// - accumulator load takes 8-bit literal, one cycle
// - accumulator stored to file address, one cycle
// - indirect modes: 00 ++, 01 --, 10 post++, 11 post--
// - relative form: pointer plus signed offset, pointer kept
// - pointer written back plus, minus or unchanged
// - indirect port has no storage, redirects to pointer
// - pointers are 16 bits and wrap
// - pointer updates leave every status flag alone
// - software reset requests a full device reset
// - software reset clears the reset instruction flag
`timescale 1ns/1ps
module lme_core #(
  parameter logic [lme_pkg::FILE_W-1:0] IND0_ADDR = lme_pkg::IND0_ADDR,
  parameter logic [lme_pkg::FILE_W-1:0] IND1_ADDR = lme_pkg::IND1_ADDR
) (
  input wire logic sys_clk,                          // core clock
  input wire logic rst_n,                            // device reset
  input wire logic por_n,                            // power-on reset
  input wire logic ce,                               // clock enable
  input wire logic instr_valid,                      // instruction present
  input wire lme_pkg::lme_op_e instr_op,             // decoded operation
  input wire logic [lme_pkg::DATA_W-1:0] instr_lit,  // literal / file
  input wire logic instr_ptr_sel,                    // pointer 0 or 1
  input wire logic [1:0] instr_mode,                 // pointer update mode
  input wire logic instr_rel,                        // relative offset form
  input wire logic [lme_pkg::OFS_W-1:0] instr_ofs,   // signed offset
  input wire logic [lme_pkg::BUS_AW-1:0] bus_addr,   // register address
  input wire logic [lme_pkg::BUS_DW-1:0] bus_wdata,  // write data
  input wire logic bus_wr,                           // write strobe
  input wire logic bus_rd,                           // read strobe
  output logic [lme_pkg::BUS_DW-1:0] bus_rdata,      // read data
  output logic [lme_pkg::BANK_W-1:0] bank_select_reg, // bank select
  output logic [lme_pkg::PCL_W-1:0] pc_high_latch,   // pc high latch
  output logic [lme_pkg::DATA_W-1:0] accum,          // working register
  output logic [lme_pkg::FLAG_W-1:0] status_flags,   // C, DC, Z
  output logic dm_we,                                // data memory write
  output logic [lme_pkg::PTR_W-1:0] dm_addr,         // data memory address
  output logic [lme_pkg::DATA_W-1:0] dm_wdata,       // data memory data
  output logic pc_advance,                           // pc plus one
  output logic sw_reset_req,                         // to reset controller
  output logic reset_instr_flag                      // power control flag
);

  localparam int PW = lme_pkg::PTR_W;

  function automatic logic [PW-1:0] file_addr(
    input logic [lme_pkg::BANK_W-1:0] bank,
    input logic [lme_pkg::FILE_W-1:0] f
  );
    file_addr = PW'({bank, f});
  endfunction

  logic [PW-1:0] ptr0;
  logic [PW-1:0] ptr1;
  logic [PW-1:0] next_ptr0;
  logic [PW-1:0] next_ptr1;
  logic [lme_pkg::BANK_W-1:0] next_bank;
  logic [lme_pkg::PCL_W-1:0] next_page;
  logic [lme_pkg::DATA_W-1:0] next_accum;
  logic [lme_pkg::FLAG_W-1:0] next_flags;
  logic next_dm_we;
  logic [PW-1:0] next_dm_addr;
  logic [lme_pkg::DATA_W-1:0] next_dm_wdata;
  logic next_pc_advance;
  logic next_ri;
  logic [lme_pkg::BUS_DW-1:0] next_rdata;
  logic sw_trigger;

  logic [lme_pkg::BANK_W-1:0] lit_bank;
  logic [lme_pkg::FILE_W-1:0] lit_file;
  logic [PW-1:0] ofs_ext;
  logic [PW-1:0] sel_ptr;
  logic [PW-1:0] eff_addr;
  logic [PW-1:0] upd_ptr;
  logic exec;

  assign lit_bank = instr_lit[lme_pkg::BANK_W-1:0];
  assign lit_file = instr_lit[lme_pkg::FILE_W-1:0];
  assign ofs_ext = {{(PW-lme_pkg::OFS_W){instr_ofs[lme_pkg::OFS_W-1]}},
                    instr_ofs};
  assign sel_ptr = instr_ptr_sel ? ptr1 : ptr0;
  assign exec = instr_valid && (instr_op != lme_pkg::LME_OP_OTHER);

  lme_ptr_unit #(
    .PTR_W(PW)
  ) u_ptr (
    .ptr(sel_ptr),
    .mode(instr_mode),
    .rel(instr_rel),
    .ofs_ext(ofs_ext),
    .eff_addr(eff_addr),
    .next_ptr(upd_ptr)
  );

  lme_rst_pulse #(
    .PULSE_CYC(lme_pkg::RST_PULSE_CYC)
  ) u_rst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .trigger(sw_trigger),
    .req(sw_reset_req)
  );

  // execution state; an instruction beats a register write in the
  // same cycle so the program's view stays consistent
  always_comb begin
    next_bank = bank_select_reg;
    next_page = pc_high_latch;
    next_accum = accum;
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    next_flags = status_flags;
    next_dm_we = 1'b0;
    next_dm_addr = dm_addr;
    next_dm_wdata = dm_wdata;
    next_pc_advance = 1'b0;
    sw_trigger = 1'b0;
    if (bus_wr) begin
      unique case (bus_addr)
        lme_pkg::OFS_BANK: next_bank = bus_wdata[lme_pkg::BANK_W-1:0];
        lme_pkg::OFS_PAGE: next_page = bus_wdata[lme_pkg::PCL_W-1:0];
        lme_pkg::OFS_ACCUM: next_accum = bus_wdata[lme_pkg::DATA_W-1:0];
        lme_pkg::OFS_PTR0: next_ptr0 = bus_wdata[PW-1:0];
        lme_pkg::OFS_PTR1: next_ptr1 = bus_wdata[PW-1:0];
        lme_pkg::OFS_STATUS: next_flags = bus_wdata[lme_pkg::FLAG_W-1:0];
        default: ;
      endcase
    end
    if (exec) begin
      next_pc_advance = (instr_op != lme_pkg::LME_OP_SW_RESET);
      unique case (instr_op)
        lme_pkg::LME_OP_NOP: ;
        lme_pkg::LME_OP_BANK: next_bank = lit_bank;
        lme_pkg::LME_OP_PAGE: next_page = lit_file;
        lme_pkg::LME_OP_ACCUM: next_accum = instr_lit;
        lme_pkg::LME_OP_STORE_FILE: begin
          next_dm_we = 1'b1;
          next_dm_wdata = accum;
          // aliased port: no storage, go through the pointer instead
          if (lit_file == IND0_ADDR) begin
            next_dm_addr = ptr0;
          end else if (lit_file == IND1_ADDR) begin
            next_dm_addr = ptr1;
          end else begin
            next_dm_addr = file_addr(bank_select_reg, lit_file);
          end
        end
        lme_pkg::LME_OP_STORE_IND: begin
          next_dm_we = 1'b1;
          next_dm_wdata = accum;
          next_dm_addr = eff_addr;
          if (instr_ptr_sel) begin
            next_ptr1 = upd_ptr;
          end else begin
            next_ptr0 = upd_ptr;
          end
        end
        lme_pkg::LME_OP_SW_RESET: sw_trigger = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bank_select_reg <= lme_pkg::BANK_RESET;
      pc_high_latch <= lme_pkg::PAGE_RESET;
      accum <= lme_pkg::ACCUM_RESET;
      ptr0 <= lme_pkg::PTR_RESET;
      ptr1 <= lme_pkg::PTR_RESET;
      status_flags <= lme_pkg::FLAG_RESET;
      dm_we <= 1'b0;
      dm_addr <= lme_pkg::PTR_RESET;
      dm_wdata <= lme_pkg::ACCUM_RESET;
      pc_advance <= 1'b0;
    end else if (ce) begin
      bank_select_reg <= next_bank;
      pc_high_latch <= next_page;
      accum <= next_accum;
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
      status_flags <= next_flags;
      dm_we <= next_dm_we;
      dm_addr <= next_dm_addr;
      dm_wdata <= next_dm_wdata;
      pc_advance <= next_pc_advance;
    end
  end

  // the flag must survive the device reset it reports, so of the two resets only power-on
  // sets it; the instruction's clear wins over a software write
  always_comb begin
    next_ri = reset_instr_flag;
    if (bus_wr && bus_addr == lme_pkg::OFS_PWR) begin
      next_ri = bus_wdata[lme_pkg::RI_BIT];
    end
    if (exec && instr_op == lme_pkg::LME_OP_SW_RESET) begin
      next_ri = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!por_n) begin
      reset_instr_flag <= lme_pkg::RI_RESET;
    end else if (ce) begin
      reset_instr_flag <= next_ri;
    end
  end

  // read data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (bus_rd) begin
      unique case (bus_addr)
        lme_pkg::OFS_BANK: next_rdata = 32'(bank_select_reg);
        lme_pkg::OFS_PAGE: next_rdata = 32'(pc_high_latch);
        lme_pkg::OFS_ACCUM: next_rdata = 32'(accum);
        lme_pkg::OFS_PTR0: next_rdata = 32'(ptr0);
        lme_pkg::OFS_PTR1: next_rdata = 32'(ptr1);
        lme_pkg::OFS_STATUS: next_rdata = 32'(status_flags);
        lme_pkg::OFS_PWR: next_rdata = 32'(reset_instr_flag);
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= '0;
    end else if (ce) begin
      bus_rdata <= next_rdata;
    end
  end

  property p_bank_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_BANK && !bus_wr)
    |=> (bank_select_reg == $past(lit_bank))
        && (status_flags == $past(status_flags));
  endproperty
  a_bank_load: assert property (p_bank_load)
    else $error("bank select not loaded from literal");

  property p_page_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_PAGE && !bus_wr)
    |=> (pc_high_latch == $past(lit_file))
        && (status_flags == $past(status_flags));
  endproperty
  a_page_load: assert property (p_page_load)
    else $error("pc high latch not loaded from literal");

  property p_accum_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_ACCUM)
    |=> (accum == $past(instr_lit)) && pc_advance && !dm_we;
  endproperty
  a_accum_load: assert property (p_accum_load)
    else $error("accumulator not loaded in one cycle");

  property p_store_file;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_FILE
     && lit_file != IND0_ADDR && lit_file != IND1_ADDR)
    |=> dm_we && (dm_wdata == $past(accum))
        && (dm_addr == PW'({$past(bank_select_reg), $past(lit_file)}));
  endproperty
  a_store_file: assert property (p_store_file)
    else $error("accumulator store went to wrong place");

  property p_pre_inc;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_IND
     && !instr_rel && instr_mode == 2'h0 && !instr_ptr_sel && !bus_wr)
    |=> dm_we && (dm_addr == PW'($past(ptr0) + 1'b1)) && (ptr0 == dm_addr);
  endproperty
  a_pre_inc: assert property (p_pre_inc)
    else $error("pre-increment address or pointer wrong");

  property p_rel_ofs;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_IND
     && instr_rel && instr_ptr_sel && !bus_wr)
    |=> (ptr1 == $past(ptr1))
        && (dm_addr == PW'($past(ptr1) + $past(ofs_ext)));
  endproperty
  a_rel_ofs: assert property (p_rel_ofs)
    else $error("relative offset store wrong");

  property p_post_dec;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_IND
     && !instr_rel && instr_mode == 2'h3 && instr_ptr_sel && !bus_wr)
    |=> (dm_addr == $past(ptr1)) && (ptr1 == PW'($past(ptr1) - 1'b1));
  endproperty
  a_post_dec: assert property (p_post_dec)
    else $error("post-decrement write-back wrong");

  property p_redirect;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_FILE
     && lit_file == IND1_ADDR)
    |=> dm_we && (dm_addr == $past(ptr1));
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("indirect port store not redirected");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_IND
     && !instr_rel && instr_mode == 2'h2 && !instr_ptr_sel
     && ptr0 == 16'hFFFF && !bus_wr)
    |=> (ptr0 == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap");

  property p_ind_flags;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_STORE_IND && !bus_wr)
    |=> $stable(status_flags);
  endproperty
  a_ind_flags: assert property (p_ind_flags)
    else $error("indirect store changed a status flag");

  property p_sw_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_SW_RESET && !bus_wr)
    |=> sw_reset_req && !reset_instr_flag && $stable(status_flags);
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset did not request reset or clear flag");

  property p_nop;
    @(posedge sys_clk) disable iff (!rst_n)
    (ce && instr_valid && instr_op == lme_pkg::LME_OP_NOP && !bus_wr)
    |=> pc_advance && !dm_we && $stable(accum) && $stable(ptr0)
        && $stable(bank_select_reg) && $stable(status_flags);
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-op changed state or did not advance pc");

endmodule // lme_core

// file: dv/tb.sv
// self-checking bench for lme_core: instruction and register port stimulus
// assumes lme_pkg is compiled first; no partner model, bench drives ports
`timescale 1ns/1ps
`define LME_CHK(nm, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, s); \
  end \
end
module tb;
  typedef struct {string nm; int sel; logic [31:0] v; int due;} lme_note_s;
  logic sys_clk, rst_n, por_n, ce, instr_valid, instr_ptr_sel, instr_rel;
  lme_pkg::lme_op_e instr_op;
  logic [7:0] instr_lit, bus_addr;
  logic [1:0] instr_mode;
  logic [5:0] instr_ofs, ofs;
  logic [31:0] bus_wdata, bus_rdata;
  logic bus_wr, bus_rd, dm_we, pc_advance, sw_reset_req, reset_instr_flag;
  logic [4:0] bank_select_reg, bank_m;
  logic [6:0] pc_high_latch;
  logic [7:0] accum, dm_wdata, acc_m, lit;
  logic [2:0] status_flags, flg_m;
  logic [15:0] dm_addr, p_m, e_m;
  int cyc, mismatches, total_checks, due;
  lme_note_s notes[$];

  lme_core lme_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
    .ce(ce), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_lit(instr_lit), .instr_ptr_sel(instr_ptr_sel),
    .instr_mode(instr_mode), .instr_rel(instr_rel), .instr_ofs(instr_ofs),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bank_select_reg(bank_select_reg), .pc_high_latch(pc_high_latch),
    .accum(accum), .status_flags(status_flags), .dm_we(dm_we),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .pc_advance(pc_advance),
    .sw_reset_req(sw_reset_req), .reset_instr_flag(reset_instr_flag));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // selector codes: 0 rdata 1 bank 2 page 3 accum 4 flags 5 we 6 addr
  // 7 wdata 8 pc_advance 9 reset request 10 reset flag
  function automatic logic [31:0] obs(int s);
    case (s)
      0: obs = bus_rdata;
      1: obs = {27'h0, bank_select_reg};
      2: obs = {25'h0, pc_high_latch};
      3: obs = {24'h0, accum};
      4: obs = {29'h0, status_flags};
      5: obs = {31'h0, dm_we};
      6: obs = {16'h0, dm_addr};
      7: obs = {24'h0, dm_wdata};
      8: obs = {31'h0, pc_advance};
      9: obs = {31'h0, sw_reset_req};
      default: obs = {31'h0, reset_instr_flag};
    endcase
  endfunction

  // notes are checked at the falling edge so registered outputs have settled
  // a due note may sit behind a later one, so the whole queue is scanned
  always @(negedge sys_clk) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due <= cyc) begin
        `LME_CHK(notes[i].nm, notes[i].v, obs(notes[i].sel))
        notes.delete(i);
      end
    end
  end

  task automatic exp(string nm, int sel, logic [31:0] v, int off = 0);
    notes.push_back('{nm, sel, v, due + off});
  endtask

  task automatic instr(lme_pkg::lme_op_e op, logic [7:0] l,
      logic s = 1'b0, logic [1:0] md = 2'h0, logic rl = 1'b0,
      logic [5:0] of = 6'h00, logic en = 1'b1);
    @(posedge sys_clk);
    due = cyc + 2;
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_lit <= l;
    instr_ptr_sel <= s;
    instr_mode <= md;
    instr_rel <= rl;
    instr_ofs <= of;
    ce <= en;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    ce <= 1'b1;
    exp("flags", 4, flg_m);
    exp("pc_adv", 8, en && op != lme_pkg::LME_OP_OTHER &&
        op != lme_pkg::LME_OP_SW_RESET);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] v, string nm);
    @(posedge sys_clk);
    due = cyc + 2;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    exp(nm, 0, v);
    exp("rd_idle", 0, 32'h0, 1);
  endtask

  function automatic logic [7:0] pa(int s);
    pa = s ? lme_pkg::OFS_PTR1 : lme_pkg::OFS_PTR0;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {rst_n, por_n, instr_valid, instr_ptr_sel, instr_rel} = 5'h00;
    {bus_wr, bus_rd, instr_mode, instr_ofs, instr_lit} = 18'h00000;
    {bus_addr, bus_wdata} = 40'h0000000000;
    ce = 1'b1;
    instr_op = lme_pkg::LME_OP_NOP;
    void'($urandom(32'h4992881a));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd(lme_pkg::OFS_PWR, 32'h1, "pwr_por");
    rd(lme_pkg::OFS_PTR1, 32'h0, "ptr1_rst");
    rd(8'h1C, 32'h0, "unmapped");
    flg_m = 3'h5;
    wr(lme_pkg::OFS_STATUS, {29'h0, flg_m});
    for (int i = 0; i < 4; i++) begin
      lit = (i == 0) ? 8'hFF : 8'($urandom);
      instr(lme_pkg::LME_OP_BANK, lit);
      bank_m = lit[4:0];
      exp("bank", 1, {27'h0, bank_m});
      instr(lme_pkg::LME_OP_PAGE, lit);
      exp("page", 2, {25'h0, lit[6:0]});
      instr(lme_pkg::LME_OP_ACCUM, lit);
      acc_m = lit;
      exp("accum", 3, {24'h0, acc_m});
      lit = 8'(2 + $urandom_range(125));
      instr(lme_pkg::LME_OP_STORE_FILE, lit);
      exp("file_we", 5, 32'h1);
      exp("file_addr", 6, {20'h0, bank_m, lit[6:0]});
      exp("file_data", 7, {24'h0, acc_m});
    end
    for (int k = 0; k < 8; k++) begin
      p_m = k[0] ? 16'h0000 : 16'hFFFF;
      e_m = k[0] ? p_m - 16'h1 : p_m + 16'h1;
      wr(pa(k / 4), {16'h0, p_m});
      instr(lme_pkg::LME_OP_STORE_IND, 8'h00, 1'(k / 4), 2'(k));
      exp("ind_we", 5, 32'h1);
      exp("ind_addr", 6, {16'h0, k[1] ? p_m : e_m});
      exp("ind_data", 7, {24'h0, acc_m});
      exp("ind_we_end", 5, 32'h0, 1);
      rd(pa(k / 4), {16'h0, e_m}, "ptr_upd");
    end
    for (int j = 0; j < 2; j++) begin
      ofs = j ? 6'h1F : 6'h20;
      p_m = j ? 16'($urandom) : 16'h0005;
      wr(pa(j), {16'h0, p_m});
      instr(lme_pkg::LME_OP_STORE_IND, 8'h00, 1'(j), 2'($urandom), 1'b1, ofs);
      exp("rel_addr", 6, {16'h0, p_m + {{10{ofs[5]}}, ofs}});
      rd(pa(j), {16'h0, p_m}, "rel_ptr");
      p_m = 16'($urandom);
      wr(pa(j), {16'h0, p_m});
      instr(lme_pkg::LME_OP_STORE_FILE, 8'(j));
      exp("alias_addr", 6, {16'h0, p_m});
      exp("alias_data", 7, {24'h0, acc_m});
      rd(pa(j), {16'h0, p_m}, "alias_ptr");
    end
    // clock enable low: the instruction must not be taken
    instr(lme_pkg::LME_OP_ACCUM, ~acc_m, 1'b0, 2'h0, 1'b0, 6'h00, 1'b0);
    exp("accum_held", 3, {24'h0, acc_m});
    instr(lme_pkg::LME_OP_NOP, 8'($urandom));
    exp("nop_accum", 3, {24'h0, acc_m});
    exp("nop_bank", 1, {27'h0, bank_m});
    exp("nop_we", 5, 32'h0);
    instr(lme_pkg::LME_OP_OTHER, 8'($urandom));
    wr(lme_pkg::OFS_PWR, 32'h1);
    instr(lme_pkg::LME_OP_SW_RESET, 8'h00);
    exp("ri_clr", 10, 32'h0);
    for (int k = 0; k < 5; k++)
      exp("rst_req", 9, 32'(k < lme_pkg::RST_PULSE_CYC), k);
    rd(lme_pkg::OFS_PWR, 32'h0, "pwr_ri");
    // let the request run out, then a device reset as the controller would
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(lme_pkg::OFS_PWR, 32'h0, "ri_kept");
    rd(lme_pkg::OFS_BANK, 32'h0, "bank_rst");
    rd(lme_pkg::OFS_STATUS, 32'h0, "flags_rst");
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule // tb
